//--- shared/rtcca_regs.vh
// register offsets, field positions and timing counts of the calendar/alarm block
`ifndef RTCCA_REGS_VH
`define RTCCA_REGS_VH
`define RTCCA_OFS_CAL_SEC    8'h40
`define RTCCA_OFS_CAL_MIN    8'h41
`define RTCCA_OFS_CAL_HOUR   8'h42
`define RTCCA_OFS_CAL_DAY    8'h43
`define RTCCA_OFS_CAL_MON    8'h44
`define RTCCA_OFS_CAL_YEAR   8'h45
`define RTCCA_OFS_ALM_SEC    8'h46
`define RTCCA_OFS_ALM_MIN    8'h47
`define RTCCA_OFS_ALM_HOUR   8'h48
`define RTCCA_OFS_ALM_DAY    8'h49
`define RTCCA_OFS_ALM_MON    8'h4a
`define RTCCA_OFS_ALM_YEAR   8'h4b
`define RTCCA_OFS_SECS_B0    8'h4c
`define RTCCA_OFS_SECS_B1    8'h4d
`define RTCCA_OFS_SECS_B2    8'h4e
`define RTCCA_OFS_SECS_B3    8'h4f
`define RTCCA_BIT_READY      7
`define RTCCA_BIT_MONITOR    6
`define RTCCA_BIT_TICK_WAKE  5
`define RTCCA_BIT_TICK_TYPE  4
`define RTCCA_BIT_TICK_ON    7
`define RTCCA_BIT_ALARM_ON   6
`define RTCCA_MAX_SEC        6'h3b
`define RTCCA_MAX_MIN        6'h3b
`define RTCCA_MAX_HOUR       5'h17
`define RTCCA_MAX_DAY        5'h1f
`define RTCCA_MAX_MON        4'hc
`define RTCCA_MAX_YEAR       6'h3f
`define RTCCA_RST_DAY        5'h01
`define RTCCA_RST_MON        4'h1
`define RTCCA_CLK_HZ         100000000
`define RTCCA_SEC_CYCLES     (`RTCCA_CLK_HZ)
`define RTCCA_FETCH_WAIT     2'h2
`endif

//--- hdl/rtcca_sync.v
// two flip-flop synchroniser for single-bit levels
`timescale 1ns/1ps
module rtcca_sync (
	clk,
	rst_n,
	d,
	q
);
	input  wire clk;
	input  wire rst_n;
	input  wire d;
	output wire q;
	reg meta_r;
	reg q_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q_r    <= 1'b0;
		end else begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end
	assign q = q_r;
endmodule

//--- hdl/rtcca_top.v
// calendar, alarm, tick and seconds counter registers of the real-time clock
`timescale 1ns/1ps
`include "rtcca_regs.vh"
module rtcca_top #(
	parameter SEC_CYCLES = `RTCCA_SEC_CYCLES
) (
	clk,
	rst_n,
	reg_addr,
	reg_wr,
	reg_rd,
	reg_wdata,
	reg_rdata,
	backup_ok,
	osc_ok,
	tick_wake_req,
	alarm_event,
	tick_event,
	rtc_running,
	clock_lock
);
	input  wire        clk;
	input  wire        rst_n;
	input  wire [7:0]  reg_addr;
	input  wire        reg_wr;
	input  wire        reg_rd;
	input  wire [7:0]  reg_wdata;
	output reg  [7:0]  reg_rdata;
	input  wire        backup_ok;
	input  wire        osc_ok;
	output wire        tick_wake_req;
	output reg         alarm_event;
	output reg         tick_event;
	output wire        rtc_running;
	output wire        clock_lock;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisation and power-on fetch of the monitor bit
	wire backup_ok_s;
	wire osc_ok_s;
	rtcca_sync u_sync_bk (.clk(clk), .rst_n(rst_n), .d(backup_ok), .q(backup_ok_s));
	rtcca_sync u_sync_osc (.clk(clk), .rst_n(rst_n), .d(osc_ok), .q(osc_ok_s));

	reg [1:0] fetch_cnt_r;
	reg       monitor_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_cnt_r <= 2'h0;
			monitor_r   <= 1'b0;
		end else if (fetch_cnt_r != 2'h3) begin
			// synchroniser is reset too, so the pin only arrives two edges after release
			fetch_cnt_r <= fetch_cnt_r + 2'h1;
			if (fetch_cnt_r == `RTCCA_FETCH_WAIT)
				monitor_r <= backup_ok_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode
	wire wr_cal_sec  = reg_wr && reg_addr == `RTCCA_OFS_CAL_SEC;
	wire wr_cal_min  = reg_wr && reg_addr == `RTCCA_OFS_CAL_MIN;
	wire wr_cal_hour = reg_wr && reg_addr == `RTCCA_OFS_CAL_HOUR;
	wire wr_cal_day  = reg_wr && reg_addr == `RTCCA_OFS_CAL_DAY;
	wire wr_cal_mon  = reg_wr && reg_addr == `RTCCA_OFS_CAL_MON;
	// a set monitor bit discards the whole year write
	wire wr_cal_year = reg_wr && reg_addr == `RTCCA_OFS_CAL_YEAR && !monitor_r;
	wire wr_alm_sec  = reg_wr && reg_addr == `RTCCA_OFS_ALM_SEC;
	wire wr_alm_min  = reg_wr && reg_addr == `RTCCA_OFS_ALM_MIN;
	wire wr_alm_hour = reg_wr && reg_addr == `RTCCA_OFS_ALM_HOUR;
	wire wr_alm_day  = reg_wr && reg_addr == `RTCCA_OFS_ALM_DAY;
	wire wr_alm_mon  = reg_wr && reg_addr == `RTCCA_OFS_ALM_MON;
	wire wr_alm_year = reg_wr && reg_addr == `RTCCA_OFS_ALM_YEAR;
	wire rd_cal_sec  = reg_rd && reg_addr == `RTCCA_OFS_CAL_SEC;
	wire rd_alm_sec  = reg_rd && reg_addr == `RTCCA_OFS_ALM_SEC;
	wire rd_secs_b0  = reg_rd && reg_addr == `RTCCA_OFS_SECS_B0;

	////////////////////////////////////////////////////////////////////////////////
	// shadow registers for calendar and alarm writes
	reg [5:0] sh_sec_r;
	reg [5:0] sh_min_r;
	reg [4:0] sh_hour_r;
	reg [4:0] sh_day_r;
	reg [3:0] sh_mon_r;
	reg [5:0] ash_sec_r;
	reg [5:0] ash_min_r;
	reg [4:0] ash_hour_r;
	reg [4:0] ash_day_r;
	reg [3:0] ash_mon_r;
	reg       tick_wake_r;
	reg       tick_type_r;
	reg       tick_on_r;
	reg       alarm_on_r;
	reg       lock_r;
	reg [5:0] a_sec_r;
	reg [5:0] a_min_r;
	reg [4:0] a_hour_r;
	reg [4:0] a_day_r;
	reg [3:0] a_mon_r;
	reg [5:0] a_year_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_sec_r    <= 6'h00;
			sh_min_r    <= 6'h00;
			sh_hour_r   <= 5'h00;
			sh_day_r    <= `RTCCA_RST_DAY;
			sh_mon_r    <= `RTCCA_RST_MON;
			ash_sec_r   <= 6'h00;
			ash_min_r   <= 6'h00;
			ash_hour_r  <= 5'h00;
			ash_day_r   <= `RTCCA_RST_DAY;
			ash_mon_r   <= `RTCCA_RST_MON;
			tick_wake_r <= 1'b0;
			tick_type_r <= 1'b0;
			tick_on_r   <= 1'b0;
			alarm_on_r  <= 1'b0;
			lock_r      <= 1'b0;
			a_sec_r     <= 6'h00;
			a_min_r     <= 6'h00;
			a_hour_r    <= 5'h00;
			a_day_r     <= `RTCCA_RST_DAY;
			a_mon_r     <= `RTCCA_RST_MON;
			a_year_r    <= 6'h00;
		end else begin
			if (wr_cal_sec)  sh_sec_r  <= reg_wdata[5:0];
			if (wr_cal_min)  sh_min_r  <= reg_wdata[5:0];
			if (wr_cal_hour) sh_hour_r <= reg_wdata[4:0];
			if (wr_cal_day)  sh_day_r  <= reg_wdata[4:0];
			if (wr_cal_mon)  sh_mon_r  <= reg_wdata[3:0];
			if (wr_cal_year) lock_r <= reg_wdata[`RTCCA_BIT_MONITOR];
			if (wr_alm_sec)  ash_sec_r  <= reg_wdata[5:0];
			if (wr_alm_min)  ash_min_r  <= reg_wdata[5:0];
			if (wr_alm_hour) ash_hour_r <= reg_wdata[4:0];
			if (wr_alm_day)  ash_day_r  <= reg_wdata[4:0];
			if (wr_alm_mon) begin
				ash_mon_r   <= reg_wdata[3:0];
				tick_wake_r <= reg_wdata[`RTCCA_BIT_TICK_WAKE];
				tick_type_r <= reg_wdata[`RTCCA_BIT_TICK_TYPE];
			end
			if (wr_alm_year) begin
				tick_on_r  <= reg_wdata[`RTCCA_BIT_TICK_ON];
				alarm_on_r <= reg_wdata[`RTCCA_BIT_ALARM_ON];
				a_year_r   <= reg_wdata[5:0];
				a_sec_r    <= ash_sec_r;
				a_min_r    <= ash_min_r;
				a_hour_r   <= ash_hour_r;
				a_day_r    <= ash_day_r;
				a_mon_r    <= ash_mon_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// running calendar and seconds counter
	reg [31:0] prescale_r;
	reg        run_r;
	reg [5:0]  c_sec_r;
	reg [5:0]  c_min_r;
	reg [4:0]  c_hour_r;
	reg [4:0]  c_day_r;
	reg [3:0]  c_mon_r;
	reg [5:0]  c_year_r;
	reg [31:0] secs_r;
	reg        sec_pulse_r;
	reg        min_pulse_r;

	wire sec_tick = run_r && osc_ok_s && prescale_r == SEC_CYCLES - 1;
	wire sec_wrap  = c_sec_r == `RTCCA_MAX_SEC;
	wire min_wrap  = c_min_r == `RTCCA_MAX_MIN;
	wire hour_wrap = c_hour_r == `RTCCA_MAX_HOUR;
	wire day_wrap  = c_day_r == `RTCCA_MAX_DAY;
	wire mon_wrap  = c_mon_r == `RTCCA_MAX_MON;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_r  <= 32'h0;
			run_r       <= 1'b0;
			c_sec_r     <= 6'h00;
			c_min_r     <= 6'h00;
			c_hour_r    <= 5'h00;
			c_day_r     <= `RTCCA_RST_DAY;
			c_mon_r     <= `RTCCA_RST_MON;
			c_year_r    <= 6'h00;
			secs_r      <= 32'h0;
			sec_pulse_r <= 1'b0;
			min_pulse_r <= 1'b0;
		end else begin
			sec_pulse_r <= sec_tick;
			min_pulse_r <= sec_tick && sec_wrap;
			if (wr_cal_year) begin
				run_r      <= 1'b1;
				prescale_r <= 32'h0;
				c_sec_r    <= sh_sec_r;
				c_min_r    <= sh_min_r;
				c_hour_r   <= sh_hour_r;
				c_day_r    <= sh_day_r;
				c_mon_r    <= sh_mon_r;
				c_year_r   <= reg_wdata[5:0];
			end else if (run_r && osc_ok_s) begin
				prescale_r <= sec_tick ? 32'h0 : prescale_r + 32'h1;
				if (sec_tick) begin
					secs_r  <= secs_r + 32'h1;
					c_sec_r <= sec_wrap ? 6'h00 : c_sec_r + 6'h01;
					if (sec_wrap) begin
						c_min_r <= min_wrap ? 6'h00 : c_min_r + 6'h01;
						if (min_wrap) begin
							c_hour_r <= hour_wrap ? 5'h00 : c_hour_r + 5'h01;
							// simple 31-day months; no month-length table kept
							if (hour_wrap) begin
								c_day_r <= day_wrap ? `RTCCA_RST_DAY : c_day_r + 5'h01;
								if (day_wrap) begin
									c_mon_r <= mon_wrap ? `RTCCA_RST_MON : c_mon_r + 4'h1;
									if (mon_wrap)
										c_year_r <= c_year_r + 6'h01;
								end
							end
						end
					end
				end
			end
		end
	end
	assign rtc_running = run_r;
	assign clock_lock  = lock_r;

	////////////////////////////////////////////////////////////////////////////////
	// tick and alarm events, cause field
	reg [1:0] cause_r;
	wire match = c_sec_r == a_sec_r && c_min_r == a_min_r && c_hour_r == a_hour_r &&
		c_day_r == a_day_r && c_mon_r == a_mon_r && c_year_r == a_year_r;
	wire tick_now  = tick_on_r && (tick_type_r ? min_pulse_r : sec_pulse_r);
	wire alarm_now = alarm_on_r && sec_pulse_r && match;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_r     <= 2'b00;
			tick_event  <= 1'b0;
			alarm_event <= 1'b0;
		end else begin
			tick_event  <= tick_now;
			alarm_event <= alarm_now;
			// read clears the cause; a new event in the same cycle still wins
			cause_r[0] <= tick_now  | (cause_r[0] & ~rd_alm_sec);
			cause_r[1] <= alarm_now | (cause_r[1] & ~rd_alm_sec);
		end
	end
	assign tick_wake_req = tick_wake_r && tick_event;

	////////////////////////////////////////////////////////////////////////////////
	// snapshots for coherent reads
	reg [5:0]  s_min_r;
	reg [4:0]  s_hour_r;
	reg [4:0]  s_day_r;
	reg [3:0]  s_mon_r;
	reg [5:0]  s_year_r;
	reg [23:0] s_secs_hi_r;
	reg        ready_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_min_r     <= 6'h00;
			s_hour_r    <= 5'h00;
			s_day_r     <= `RTCCA_RST_DAY;
			s_mon_r     <= `RTCCA_RST_MON;
			s_year_r    <= 6'h00;
			s_secs_hi_r <= 24'h0;
			ready_r     <= 1'b0;
		end else begin
			// calendar is stable except in the cycle it advances or reloads
			ready_r <= run_r && !sec_tick && !wr_cal_year;
			if (rd_cal_sec) begin
				s_min_r  <= c_min_r;
				s_hour_r <= c_hour_r;
				s_day_r  <= c_day_r;
				s_mon_r  <= c_mon_r;
				s_year_r <= c_year_r;
			end
			if (rd_secs_b0)
				s_secs_hi_r <= secs_r[31:8];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data, registered one cycle after the read strobe
	reg [7:0] rdata_nxt;
	always @* begin
		rdata_nxt = 8'h00;
		case (reg_addr)
		`RTCCA_OFS_CAL_SEC:  rdata_nxt = {ready_r, 1'b0, c_sec_r};
		`RTCCA_OFS_CAL_MIN:  rdata_nxt = {2'b00, s_min_r};
		`RTCCA_OFS_CAL_HOUR: rdata_nxt = {3'b000, s_hour_r};
		`RTCCA_OFS_CAL_DAY:  rdata_nxt = {3'b000, s_day_r};
		`RTCCA_OFS_CAL_MON:  rdata_nxt = {4'h0, s_mon_r};
		`RTCCA_OFS_CAL_YEAR: rdata_nxt = {1'b0, monitor_r, s_year_r};
		`RTCCA_OFS_ALM_SEC:  rdata_nxt = {cause_r, ash_sec_r};
		`RTCCA_OFS_ALM_MIN:  rdata_nxt = {2'b00, ash_min_r};
		`RTCCA_OFS_ALM_HOUR: rdata_nxt = {3'b000, ash_hour_r};
		`RTCCA_OFS_ALM_DAY:  rdata_nxt = {3'b000, ash_day_r};
		`RTCCA_OFS_ALM_MON:  rdata_nxt = {2'b00, tick_wake_r, tick_type_r, ash_mon_r};
		`RTCCA_OFS_ALM_YEAR: rdata_nxt = {tick_on_r, alarm_on_r, a_year_r};
		`RTCCA_OFS_SECS_B0:  rdata_nxt = secs_r[7:0];
		`RTCCA_OFS_SECS_B1:  rdata_nxt = s_secs_hi_r[7:0];
		`RTCCA_OFS_SECS_B2:  rdata_nxt = s_secs_hi_r[15:8];
		`RTCCA_OFS_SECS_B3:  rdata_nxt = s_secs_hi_r[23:16];
		default:             rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
	end
endmodule

//--- tb/rtcca_host.sv
// host model issuing one-cycle register strobes for the bench
`timescale 1ns/1ps
module rtcca_host (
	input  logic       clk,
	input  logic       rst_n,
	input  logic       go,
	input  logic       op_wr,
	input  logic [7:0] op_addr,
	input  logic [7:0] op_wdata,
	output logic       done,
	output logic [7:0] op_rdata,
	output logic [7:0] reg_addr,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [7:0] reg_wdata,
	input  logic [7:0] reg_rdata
);
	assign op_rdata = reg_rdata;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_wr    <= 1'b0;
			reg_rd    <= 1'b0;
			done      <= 1'b0;
			reg_addr  <= 8'h00;
			reg_wdata <= 8'h00;
		end else begin
			// one strobe per request, order left to the caller
			reg_wr    <= go & op_wr;
			reg_rd    <= go & ~op_wr;
			done      <= reg_wr | reg_rd;
			// released bus toggles so a stale value cannot pass as held
			reg_addr  <= go ? op_addr : ~reg_addr;
			reg_wdata <= go ? op_wdata : ~reg_wdata;
		end
	end
endmodule

//--- tb/rtcca_top_chk.sv
// port assertions for the calendar/alarm register block
`timescale 1ns/1ps
module rtcca_chk (
	input logic       clk,
	input logic       rst_n,
	input logic [7:0] reg_addr,
	input logic       reg_wr,
	input logic       reg_rd,
	input logic [7:0] reg_wdata,
	input logic [7:0] reg_rdata,
	input logic       tick_wake_req,
	input logic       alarm_event,
	input logic       tick_event,
	input logic       rtc_running,
	input logic       clock_lock
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	property p_run_cause; $rose(rtc_running) |-> $past(reg_wr && reg_addr == 8'h45); endproperty
	a_run_cause: assert property (p_run_cause) else $error("run without year write");
	property p_run_hold; rtc_running |=> rtc_running; endproperty
	a_run_hold: assert property (p_run_hold) else $error("clock stopped");
	property p_lock; $changed(clock_lock) |->
		$past(reg_wr && reg_addr == 8'h45) && $past(reg_wdata[6]) == clock_lock; endproperty
	a_lock: assert property (p_lock) else $error("lock change without year write");
	// wake bit mirrored from bus writes, so the check does not lean on the design
	logic wake_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wake_r <= 1'b0;
		else if (reg_wr && reg_addr == 8'h4a)
			wake_r <= reg_wdata[5];
	end
	property p_wake; tick_wake_req == (tick_event && wake_r); endproperty
	a_wake: assert property (p_wake) else $error("wake without tick");
	property p_tick_gap; tick_event |=> !tick_event [*8]; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
	property p_alarm_pulse; alarm_event |=> !alarm_event; endproperty
	a_alarm_pulse: assert property (p_alarm_pulse) else $error("alarm pulse too long");
	property p_sec_rd; reg_rd && reg_addr == 8'h40 |=> !reg_rdata[6] && reg_rdata[5:0] <= 6'h3b;
	endproperty
	a_sec_rd: assert property (p_sec_rd) else $error("seconds read out of range");
	property p_hour_rd; reg_rd && reg_addr == 8'h42 |=> reg_rdata <= 8'h17; endproperty
	a_hour_rd: assert property (p_hour_rd) else $error("hours read out of range");
	property p_mon_rd; reg_rd && reg_addr == 8'h44 |=> reg_rdata inside {[8'h01:8'h0c]}; endproperty
	a_mon_rd: assert property (p_mon_rd) else $error("month read out of range");
	property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	////////////////////////////////////////////////////////////////////////
	c_run: cover property ($rose(rtc_running));
	c_alarm: cover property (alarm_event);
	c_wake: cover property (tick_wake_req);
endmodule

//--- tb/tb_top.sv
// self-checking bench of the calendar/alarm register block
`timescale 1ns/1ps
module tb_top;
	localparam int SEC = 50;
	logic        clk = 1'b0, rst_n = 1'b0, backup_ok = 1'b0, osc_ok = 1'b0;
	logic        go = 1'b0, op_wr = 1'b0, done, reg_wr, reg_rd;
	logic [7:0]  op_addr = 8'h00, op_wdata = 8'h00, op_rdata, reg_addr, reg_wdata, reg_rdata, q;
	logic        tick_wake_req, alarm_event, tick_event, rtc_running, clock_lock;
	logic [15:0] rnd = 16'hae53;
	int          failures = 0, n_compared = 0, n_tick = 0, n_alm = 0, n_wake = 0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		n_tick <= n_tick + (tick_event === 1'b1);
		n_alm  <= n_alm + (alarm_event === 1'b1);
		n_wake <= n_wake + (tick_wake_req === 1'b1);
	end
	rtcca_host i_host (.clk(clk), .rst_n(rst_n), .go(go), .op_wr(op_wr), .op_addr(op_addr),
		.op_wdata(op_wdata), .done(done), .op_rdata(op_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	rtcca_top #(.SEC_CYCLES(SEC)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.backup_ok(backup_ok), .osc_ok(osc_ok), .tick_wake_req(tick_wake_req),
		.alarm_event(alarm_event), .tick_event(tick_event), .rtc_running(rtc_running),
		.clock_lock(clock_lock));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic test_done;
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge clk);
		go       <= 1'b1;
		op_wr    <= w;
		op_addr  <= a;
		op_wdata <= d;
		@(posedge clk);
		go <= 1'b0;
		for (k = 0; k < 10 && done !== 1'b1; k++) @(negedge clk);
		if (done !== 1'b1) begin
			failures++;
			test_done;
		end
		q = op_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	task automatic wait_tick(input int lim);
		int k;
		for (k = 0; k < lim && tick_event !== 1'b1; k++) @(negedge clk);
		if (tick_event !== 1'b1) begin
			failures++;
			test_done;
		end
	endtask
	task automatic osc(input logic v);
		@(posedge clk);
		osc_ok <= v;
	endtask
	// reserved and read-only bits are written as ones on purpose
	task automatic set_cal(input logic [5:0] s, mi, input logic [4:0] h, d,
		input logic [3:0] mo, input logic [6:0] y, input logic [7:0] e0);
		acc(1'b1, 8'h40, {2'b11, s});
		acc(1'b1, 8'h41, {2'b11, mi});
		acc(1'b1, 8'h42, {3'b111, h});
		acc(1'b1, 8'h43, {3'b111, d});
		acc(1'b1, 8'h44, {4'hf, mo});
		rdc(8'h40, e0);
		acc(1'b1, 8'h45, {1'b1, y});
	endtask
	task automatic chk_cal(input logic r, input logic [5:0] s, mi, input logic [4:0] h, d,
		input logic [3:0] mo, input logic [5:0] y);
		rdc(8'h40, {r, 1'b0, s});
		rdc(8'h41, {2'b00, mi});
		rdc(8'h42, {3'b000, h});
		rdc(8'h43, {3'b000, d});
		rdc(8'h44, {4'h0, mo});
		rdc(8'h45, {2'b00, y});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [5:0] s, mi, y;
		logic [4:0] h, d;
		logic [3:0] mo;
		logic [5:0] ps;
		logic       pr;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk_cal(1'b0, 6'h00, 6'h00, 5'h00, 5'h01, 4'h1, 6'h00);
		mi = 6'h00;
		ps = 6'h00;
		pr = 1'b0;
		for (int i = 0; i < 4; i++) begin
			rdc(8'h40, {pr, 1'b0, ps});
			rdc(8'h41, {2'b00, mi});
			rnd = lfsr(rnd);
			s = (i == 0) ? 6'h3b : 6'(rnd % 60);
			mi = (i == 0) ? 6'h3b : 6'(rnd[15:8] % 60);
			h = (i == 0) ? 5'h17 : 5'(rnd % 24);
			d = (i == 0) ? 5'h1f : 5'(rnd % 31 + 1);
			mo = (i == 0) ? 4'hc : 4'(rnd[11:4] % 12 + 1);
			y = (i == 0) ? 6'h3f : rnd[9:4];
			set_cal(s, mi, h, d, mo, {i[0], y}, {pr, 1'b0, ps});
			chk({6'h00, rtc_running, clock_lock}, {6'h00, 1'b1, i[0]});
			chk_cal(1'b1, s, mi, h, d, mo, y);
			ps = s;
			pr = 1'b1;
		end
		set_cal(6'h3b, 6'h3b, 5'h17, 5'h1f, 4'hc, 7'h05, {pr, 1'b0, ps});
		acc(1'b1, 8'h46, 8'h00);
		acc(1'b1, 8'h49, 8'h01);
		acc(1'b1, 8'h4a, 8'h21);
		acc(1'b1, 8'h4b, 8'hc6);
		rdc(8'h4a, 8'h21);
		rdc(8'h4b, 8'hc6);
		chk(8'(n_tick), 8'h00);
		osc(1'b1);
		wait_tick(2 * SEC + 10);
		osc(1'b0);
		chk_cal(1'b1, 6'h00, 6'h00, 5'h00, 5'h01, 4'h1, 6'h06);
		rdc(8'h46, 8'hc0);
		rdc(8'h46, 8'h00);
		chk({8'(n_alm)}, 8'h01);
		chk({8'(n_wake)}, 8'h01);
		rdc(8'h4c, 8'h01);
		rdc(8'h4d, 8'h00);
		rdc(8'h4e, 8'h00);
		rdc(8'h4f, 8'h00);
		acc(1'b1, 8'h4b, 8'h46);
		osc(1'b1);
		repeat (3 * SEC) @(posedge clk);
		chk(8'(n_tick), 8'h01);
		chk(8'(n_alm), 8'h01);
		// alarm set to the coming minute boundary but left disabled
		acc(1'b1, 8'h47, 8'h01);
		acc(1'b1, 8'h4a, 8'h11);
		acc(1'b1, 8'h4b, 8'h86);
		wait_tick(61 * SEC + 10);
		osc(1'b0);
		rdc(8'h40, 8'h80);
		chk(8'(n_wake), 8'h01);
		chk(8'(n_alm), 8'h01);
		rdc(8'h46, 8'h40);
		@(posedge clk);
		rst_n     <= 1'b0;
		backup_ok <= 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(8'h40, 8'h00);
		rdc(8'h45, 8'h40);
		acc(1'b1, 8'h45, 8'h3f);
		rdc(8'h40, 8'h00);
		rdc(8'h45, 8'h40);
		chk({6'h00, rtc_running, clock_lock}, 8'h00);
		test_done;
	end
endmodule
bind rtcca_top rtcca_chk i_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.tick_wake_req(tick_wake_req), .alarm_event(alarm_event), .tick_event(tick_event),
	.rtc_running(rtc_running), .clock_lock(clock_lock));
